// File: verilog/serial_dac_load_control.sv
// digital front end of a sixteen bit serial-input voltage converter
`timescale 1ns/1ps
module serial_dac_load_control (
   // ======================================================
   // system side
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // ======================================================
   // serial link
   input  wire logic                serial_clk,
   input  wire logic                frame_sel_n,
   input  wire logic                serial_data_in,
   input  wire logic                serial_data_out_in,
   output      logic                serial_data_out_out,
   output      logic                serial_data_out_oe,
   // ======================================================
   // control pins
   input  wire logic                load_strobe_n,
   input  wire logic                output_clear_n,
   input  wire logic                power_down_n,
   // ======================================================
   // converter side
   output      dac_load_pkg::code_t analog_output_code_q,
   output      logic                analog_ground_q,
   output      logic                converter_powered_down_q,
   output      dac_load_pkg::code_t input_word_q,
   output      logic                dac_update_q,
   output      logic                line_level_q
);
   import dac_load_pkg::*;

   // ======================================================
   // declarations
   logic              link_rst_q;
   code_t             shift_word;
   logic              frame_full;
   logic              sdo_oe;
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_sync;

   logic              s_frame;
   logic              s_strobe;
   logic              s_clear;
   logic              s_pdown;
   logic              s_line;
   logic              s_full;

   logic              frame_prev_q;
   logic              strobe_prev_q;
   logic              clear_prev_q;

   logic              frame_rise;
   logic              strobe_fall;
   logic              clear_fall;
   logic              word_ok;
   logic              sync_load;
   logic              async_load;
   logic              dac_load;

   code_t             input_q;
   code_t             input_d;
   code_t             dac_q;
   code_t             dac_d;
   logic              cleared_q;
   logic              cleared_d;
   code_t             out_code_d;

   // ======================================================
   // reset for the link domain
   // link clock may be stopped, so its flops clear
   // asynchronously from this registered copy
   always_ff @(posedge clock) begin
      link_rst_q <= sys_rst;
   end

   // ======================================================
   // serial clock domain
   link_shifter u_link_shifter (
      .serial_clk     (serial_clk),
      .link_rst       (link_rst_q),
      .frame_sel_n    (frame_sel_n),
      .serial_data_in (serial_data_in),
      .shift_word     (shift_word),
      .frame_full     (frame_full),
      .sdo_oe         (sdo_oe)
   );

   // open drain: only ever drives low
   assign serial_data_out_out = 1'b0;
   assign serial_data_out_oe  = sdo_oe;

   // ======================================================
   // pin and link-flag synchronisers
   assign pins_raw[LN_FRAME]  = frame_sel_n;
   assign pins_raw[LN_STROBE] = load_strobe_n;
   assign pins_raw[LN_CLEAR]  = output_clear_n;
   assign pins_raw[LN_PDOWN]  = power_down_n;
   assign pins_raw[LN_LINE]   = serial_data_out_in;
   assign pins_raw[LN_FULL]   = frame_full;

   sync_level #(
      .WIDTH     (SYNC_W),
      .RESET_VAL (SYNC_IDLE)
   ) u_sync_level (
      .clock    (clock),
      .sys_rst  (sys_rst),
      .async_in (pins_raw),
      .sync_out (pins_sync)
   );

   assign s_frame  = pins_sync[LN_FRAME];
   assign s_strobe = pins_sync[LN_STROBE];
   assign s_clear  = pins_sync[LN_CLEAR];
   assign s_pdown  = pins_sync[LN_PDOWN];
   assign s_line   = pins_sync[LN_LINE];
   assign s_full   = pins_sync[LN_FULL];

   // ======================================================
   // edge history
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         frame_prev_q  <= 1'b1;
         strobe_prev_q <= 1'b1;
         clear_prev_q  <= 1'b1;
      end else begin
         frame_prev_q  <= s_frame;
         strobe_prev_q <= s_strobe;
         clear_prev_q  <= s_clear;
      end
   end

   // ======================================================
   // event decode
   assign frame_rise  = s_frame & ~frame_prev_q;
   assign strobe_fall = ~s_strobe & strobe_prev_q;
   assign clear_fall  = ~s_clear & clear_prev_q;

   // link is quiet once frame high is seen here,
   // so the shift word is stable when sampled
   assign word_ok     = frame_rise & s_full;

   // strobe held low: update with the frame end
   assign sync_load   = frame_rise & ~s_strobe;
   // strobe high while shifting: update on its fall
   assign async_load  = strobe_fall;
   assign dac_load    = sync_load | async_load;

   // ======================================================
   // next values
   assign input_d = word_ok ? shift_word : input_q;
   assign dac_d   = dac_load ? input_d : dac_q;

   // clear grounds the output only; registers keep going
   assign cleared_d = (!s_clear || clear_fall) ? 1'b1 :
                      dac_load ? 1'b0 : cleared_q;

   // midscale is the zero-volt code
   assign out_code_d = cleared_d ? GROUND_CODE : dac_d;

   // ======================================================
   // input and converter registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         input_q <= MIDSCALE_CODE;
         dac_q   <= MIDSCALE_CODE;
      end else begin
         input_q <= input_d;
         dac_q   <= dac_d;
      end
   end

   // ======================================================
   // output state
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cleared_q <= 1'b0;
      end else begin
         cleared_q <= cleared_d;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         analog_output_code_q <= MIDSCALE_CODE;
         analog_ground_q      <= 1'b0;
      end else begin
         analog_output_code_q <= out_code_d;
         analog_ground_q      <= cleared_d;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         converter_powered_down_q <= 1'b0;
      end else begin
         converter_powered_down_q <= ~s_pdown;
      end
   end

   // ======================================================
   // status copies
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         input_word_q <= MIDSCALE_CODE;
         dac_update_q <= 1'b0;
         line_level_q <= 1'b1;
      end else begin
         input_word_q <= input_d;
         dac_update_q <= dac_load;
         line_level_q <= s_line;
      end
   end

endmodule : serial_dac_load_control

// File: inc/dac_load_pkg.sv
// constants shared by the serial converter load control block
package dac_load_pkg;

   // ======================================================
   // word layout
   localparam int unsigned CODE_W  = 16;
   localparam int unsigned CNT_W   = 5;
   localparam int unsigned MSB_POS = CODE_W - 1;

   typedef logic [CODE_W-1:0] code_t;
   typedef logic [CNT_W-1:0]  count_t;

   // ======================================================
   // codes and counts
   localparam code_t  MIDSCALE_CODE = 16'h8000;
   localparam code_t  GROUND_CODE   = 16'h8000;
   localparam count_t FRAME_BITS    = 5'h10;
   localparam count_t LAST_BIT_CNT  = 5'h0F;
   localparam count_t COUNT_ONE     = 5'h01;
   localparam count_t COUNT_ZERO    = 5'h00;

   // ======================================================
   // synchroniser lane positions and idle levels
   localparam int unsigned SYNC_W    = 6;
   localparam int unsigned LN_FRAME  = 0;
   localparam int unsigned LN_STROBE = 1;
   localparam int unsigned LN_CLEAR  = 2;
   localparam int unsigned LN_PDOWN  = 3;
   localparam int unsigned LN_LINE   = 4;
   localparam int unsigned LN_FULL   = 5;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h1F;

endpackage : dac_load_pkg

// File: verilog/sync_level.sv
// two flip-flop level synchroniser, one lane per bit
`timescale 1ns/1ps
module sync_level #(
   parameter int unsigned      WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   // first stage feeds only the second
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_q   <= RESET_VAL;
         stable_q <= RESET_VAL;
      end else begin
         meta_q   <= async_in;
         stable_q <= meta_q;
      end
   end

   assign sync_out = stable_q;
endmodule : sync_level

// File: verilog/link_shifter.sv
// serial clock domain: sixteen bit shift register, frame count, open-drain drive
`timescale 1ns/1ps
module link_shifter
   import dac_load_pkg::*;
(
   input  wire logic                 serial_clk,
   input  wire logic                 link_rst,
   input  wire logic                 frame_sel_n,
   input  wire logic                 serial_data_in,
   output      dac_load_pkg::code_t  shift_word,
   output      logic                 frame_full,
   output      logic                 sdo_oe
);
   code_t  shift_q;
   code_t  shift_d;
   count_t count_q;
   logic   full_q;
   logic   oe_q;
   logic   frame_idle;
   logic   count_done;

   // ======================================================
   // decode
   assign shift_d    = {shift_q[MSB_POS-1:0], serial_data_in};
   assign frame_idle = frame_sel_n | link_rst;
   assign count_done = (count_q == FRAME_BITS);

   // ======================================================
   // shift register, falling serial edge only
   always_ff @(negedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         shift_q <= MIDSCALE_CODE;
      end else if (!frame_sel_n) begin
         shift_q <= shift_d;
      end
   end

   // count cleared while frame idle; saturates at a full word
   always_ff @(negedge serial_clk or posedge frame_idle) begin
      if (frame_idle) begin
         count_q <= COUNT_ZERO;
      end else if (!count_done) begin
         count_q <= count_q + COUNT_ONE;
      end
   end

   // word complete once sixteenth edge lands
   always_ff @(negedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         full_q <= 1'b0;
      end else if (!frame_sel_n) begin
         full_q <= (count_q >= LAST_BIT_CNT);
      end
   end

   // pull low for a zero msb, release for a one
   always_ff @(negedge serial_clk or posedge link_rst) begin
      if (link_rst) begin
         oe_q <= 1'b0;
      end else if (!frame_sel_n) begin
         oe_q <= ~shift_d[MSB_POS];
      end
   end

   assign shift_word = shift_q;
   assign frame_full = full_q;
   assign sdo_oe     = oe_q;
endmodule : link_shifter

// File: bench/serial_dac_load_control_chk.sv
// port assertions for the serial converter load control
`timescale 1ns/1ps
module serial_dac_load_control_chk
   import dac_load_pkg::*;
(
   input wire logic                clock,
   input wire logic                sys_rst,
   input wire logic                serial_clk,
   input wire logic                frame_sel_n,
   input wire logic                serial_data_in,
   input wire logic                serial_data_out_in,
   input wire logic                serial_data_out_out,
   input wire logic                serial_data_out_oe,
   input wire logic                load_strobe_n,
   input wire logic                output_clear_n,
   input wire logic                power_down_n,
   input wire dac_load_pkg::code_t analog_output_code_q,
   input wire logic                analog_ground_q,
   input wire logic                converter_powered_down_q,
   input wire dac_load_pkg::code_t input_word_q,
   input wire logic                dac_update_q,
   input wire logic                line_level_q
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // ======================================================
   // output pin and clear
   chk_od_low_only: assert property (serial_data_out_oe |-> !serial_data_out_out)
      else $error("serial out driven high");
   chk_ground_code: assert property (analog_ground_q |-> analog_output_code_q == GROUND_CODE)
      else $error("ground without ground code");
   chk_clear_grounds: assert property ($fell(output_clear_n) |-> ##[2:4] analog_ground_q)
      else $error("clear did not ground");
   // ======================================================
   // register loading
   chk_word_after_frame: assert property ($changed(input_word_q) |-> !$past(frame_sel_n, 6))
      else $error("input word changed outside a frame end");
   chk_strobe_load: assert property ($fell(load_strobe_n) && frame_sel_n |->
      ##[2:6] (dac_update_q && analog_output_code_q == input_word_q))
      else $error("strobe did not load");
   chk_sync_load: assert property ($rose(frame_sel_n) && !load_strobe_n |->
      ##[2:6] (dac_update_q && analog_output_code_q == input_word_q))
      else $error("frame rise did not load");
   chk_update_pulse: assert property ($changed(analog_output_code_q) && !analog_ground_q |-> dac_update_q)
      else $error("load without update pulse");
   chk_idle_stable: assert property ((frame_sel_n && load_strobe_n && output_clear_n)[*8] |->
      $stable(analog_output_code_q) && $stable(input_word_q))
      else $error("registers moved while idle");
   chk_power_state: assert property ($changed(power_down_n) ##1 $stable(power_down_n)[*4] |->
      converter_powered_down_q == !power_down_n)
      else $error("power state wrong");
   cov_sync: cover property ($rose(frame_sel_n) && !load_strobe_n);
   cov_strobe: cover property ($fell(load_strobe_n) && frame_sel_n);
   cov_clear: cover property ($rose(analog_ground_q));
endmodule : serial_dac_load_control_chk

// File: bench/host_serial_model.sv
// host serial port model driving the link pins
`timescale 1ns/1ps
module host_serial_model (
   input  wire logic       clock,
   input  wire logic       sdo_wire,
   output      logic       serial_clk,
   output      logic       frame_sel_n,
   output      logic       serial_data_in,
   output      logic [7:0] rx_bits
);
   initial begin
      serial_clk = 1'b0;
      frame_sel_n = 1'b1;
      serial_data_in = 1'b0;
      rx_bits = 8'h00;
   end
   // msb first, one bit per falling edge, 12 ns link period
   // data moves after the rise so only a falling-edge sampler sees it
   // chained receiver samples the line just before each fall past the sixteenth
   task automatic send(input logic [23:0] w, input int n);
      @(posedge clock);
      frame_sel_n <= 1'b0;
      #10;
      for (int i = n - 1; i >= 0; i--) begin
         #2 serial_clk = 1'b1;
         #3 serial_data_in = w[i];
         #6 if (n - i > 16) rx_bits = {rx_bits[6:0], sdo_wire};
         serial_clk = 1'b0;
         #1;
      end
      #5 frame_sel_n = 1'b1;
      serial_data_in = ~serial_data_in;
      repeat (6) @(posedge clock);
   endtask : send
   // pins wiggled with the frame idle
   task automatic toggle();
      repeat (8) begin
         #2 serial_data_in = ~serial_data_in;
         #3 serial_clk = 1'b1;
         #6 serial_clk = 1'b0;
         #1;
      end
   endtask : toggle
endmodule : host_serial_model

// File: bench/serial_dac_load_control_tb_top.sv
// testbench for the serial converter load control
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t got %h expected %h", $time, (a), (b)); end end
module serial_dac_load_control_tb_top;
   import dac_load_pkg::*;
   logic  clock = 1'b0;
   logic  sys_rst = 1'b1;
   logic  load_strobe_n = 1'b1;
   logic  output_clear_n = 1'b1;
   logic  power_down_n = 1'b1;
   logic  serial_clk, frame_sel_n, serial_data_in, sdo_wire, serial_data_out_out, serial_data_out_oe;
   logic  analog_ground_q, converter_powered_down_q, dac_update_q, line_level_q;
   code_t analog_output_code_q, input_word_q;
   logic  [7:0] rx_bits;
   int    n_mismatch = 0;
   int    comparisons = 0;
   always #12.5 clock = ~clock;
   assign sdo_wire = serial_data_out_oe ? serial_data_out_out : 1'b1;
   serial_dac_load_control dut_u (.clock, .sys_rst, .serial_clk, .frame_sel_n, .serial_data_in,
      .serial_data_out_in(sdo_wire), .serial_data_out_out, .serial_data_out_oe, .load_strobe_n,
      .output_clear_n, .power_down_n, .analog_output_code_q, .analog_ground_q, .converter_powered_down_q,
      .input_word_q, .dac_update_q, .line_level_q);
   host_serial_model m_u (.clock, .sdo_wire, .serial_clk, .frame_sel_n, .serial_data_in, .rx_bits);
   task cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : cyc
   task strobe();
      @(posedge clock);
      load_strobe_n <= 1'b0;
      cyc(3);
      @(posedge clock);
      load_strobe_n <= 1'b1;
      cyc(8);
   endtask : strobe
   task t_reset();
      `CHK(input_word_q, MIDSCALE_CODE)
      `CHK(analog_output_code_q, MIDSCALE_CODE)
      `CHK(analog_ground_q, 1'b0)
      `CHK(line_level_q, 1'b1)
   endtask : t_reset
   task t_async();
      m_u.send(24'h001234, 16);
      cyc(8);
      `CHK(input_word_q, 16'h1234)
      `CHK(analog_output_code_q, MIDSCALE_CODE)
      strobe();
      `CHK(analog_output_code_q, 16'h1234)
   endtask : t_async
   task t_sync();
      code_t w [2];
      w = '{16'h0000, 16'hFFFF};
      @(posedge clock);
      load_strobe_n <= 1'b0;
      cyc(8);
      foreach (w[i]) begin
         m_u.send({8'h00, w[i]}, 16);
         cyc(8);
         `CHK(analog_output_code_q, w[i])
      end
      @(posedge clock);
      load_strobe_n <= 1'b1;
      cyc(10);
   endtask : t_sync
   task t_short();
      m_u.send(24'h0000A5, 8);
      cyc(8);
      `CHK(input_word_q, 16'hFFFF)
      `CHK(analog_output_code_q, 16'hFFFF)
   endtask : t_short
   task t_chain();
      m_u.send(24'hC35AA5, 24);
      cyc(8);
      `CHK(input_word_q, 16'h5AA5)
      `CHK(rx_bits, 8'hC3)
      `CHK(line_level_q, 1'b0)
      strobe();
      `CHK(analog_output_code_q, 16'h5AA5)
   endtask : t_chain
   task t_idle();
      m_u.toggle();
      cyc(8);
      `CHK(input_word_q, 16'h5AA5)
      `CHK(analog_output_code_q, 16'h5AA5)
   endtask : t_idle
   task t_clear();
      @(posedge clock);
      output_clear_n <= 1'b0;
      cyc(6);
      `CHK(analog_ground_q, 1'b1)
      `CHK(analog_output_code_q, GROUND_CODE)
      `CHK(input_word_q, 16'h5AA5)
      @(posedge clock);
      output_clear_n <= 1'b1;
      strobe();
      `CHK(analog_ground_q, 1'b0)
      `CHK(analog_output_code_q, 16'h5AA5)
   endtask : t_clear
   task t_power();
      @(posedge clock);
      power_down_n <= 1'b0;
      cyc(6);
      `CHK(converter_powered_down_q, 1'b1)
      @(posedge clock);
      power_down_n <= 1'b1;
      cyc(6);
      `CHK(converter_powered_down_q, 1'b0)
      @(posedge clock);
      sys_rst <= 1'b1;
      cyc(8);
      @(posedge clock);
      sys_rst <= 1'b0;
      cyc(3);
      t_reset();
   endtask : t_power
   task give_verdict();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      cyc(3);
      t_reset();
      t_async();
      t_sync();
      t_short();
      t_chain();
      t_idle();
      t_clear();
      t_power();
      give_verdict();
   end
   initial begin
      #100000;
      n_mismatch++;
      give_verdict();
   end
endmodule : serial_dac_load_control_tb_top
bind serial_dac_load_control serial_dac_load_control_chk chk_u (.clock, .sys_rst, .serial_clk, .frame_sel_n,
   .serial_data_in, .serial_data_out_in, .serial_data_out_out, .serial_data_out_oe, .load_strobe_n,
   .output_clear_n, .power_down_n, .analog_output_code_q, .analog_ground_q, .converter_powered_down_q,
   .input_word_q, .dac_update_q, .line_level_q);
